// *** logic/dpc_pkg.sv ***
// constants shared by the digipot control block
// assumes a 10 MHz core clock and a slow external nvm array
package dpc_pkg;
	// bus address and command codes
	localparam logic [3:0] DEV_ADDR_HI  = 4'h9;
	localparam logic [6:0] BCAST_ADDR   = 7'h47;
	localparam logic [7:0] GC_ADDR      = 8'h00;
	localparam logic [7:0] GC_RESET     = 8'h06;
	localparam logic [7:0] CMD_STATUS   = 8'hD0;
	localparam logic [7:0] CMD_CONFIG   = 8'hD1;
	localparam logic [7:0] CMD_PROTECT  = 8'hD3;
	localparam logic [7:0] CMD_WIPER    = 8'h21;
	localparam logic [7:0] CMD_USER1    = 8'h25;
	localparam logic [7:0] CMD_USER2    = 8'h26;
	// field positions
	localparam int ST_USER_FLAG = 15;
	localparam int ST_FACT_FLAG = 14;
	localparam int ST_BUSY      = 13;
	localparam int CF_LOCK      = 13;
	localparam int CF_PDN_LO    = 3;
	localparam int CF_REF_EN    = 2;
	localparam int CF_SPAN_LO   = 0;
	localparam int PR_KEY_LO    = 12;
	localparam int PR_SOFT_LO   = 2;
	localparam int PR_RECALL    = 1;
	localparam int PR_STORE     = 0;
	localparam int DATA_LO      = 4;
	// key codes
	localparam logic [3:0] KEY_SOFT     = 4'hA;
	localparam logic [3:0] KEY_UNLOCK   = 4'h5;
	// factory reset values and fixed codes
	localparam logic [1:0] PDN_HIZ      = 2'h2;
	localparam logic [1:0] PDN_ON       = 2'h0;
	localparam logic [7:0] WIPER_RST    = 8'h00;
	localparam logic [1:0] SPAN_RST     = 2'h0;
	localparam logic [9:0] CRC_POLY     = 10'h233;
	localparam logic [7:0] IDENT_CODE   = 8'h00; // arbitrary value
	// timing
	localparam int CLK_KHZ      = 10_000;
	localparam int POR_DELAY_MS = 30;
	localparam int POR_CYC      = POR_DELAY_MS * CLK_KHZ;
	localparam int NVM_OP_CYC   = 16;
	// persistent image: lock, pdn, ref, span, wiper, user1, user2
	localparam int IMG_W        = 30;
endpackage

// *** logic/dpc_sync.sv ***
// two-stage synchroniser for asynchronous pins
// assumes inputs change without regard to clock_i
`timescale 1ns/1ps
module dpc_sync
	import dpc_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= '1;
			q_o    <= '1;
		end
		else
		begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule

// *** logic/dpc_crc10.sv ***
// combinational crc over a data word, msb first, zero seed
// assumes the caller registers the result where timing needs it
`timescale 1ns/1ps
module dpc_crc10
	import dpc_pkg::*;
#(
	parameter int DW = 16
)(
	input  wire logic [DW-1:0] data_i,
	output logic      [9:0]    crc_o
);
	// bitwise shift through the generator
	always_comb
	begin
		logic [9:0] c;
		c = '0;
		for (int i = DW - 1; i >= 0; i--)
		begin
			if (c[9] ^ data_i[i])
				c = {c[8:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[8:0], 1'b0};
		end
		crc_o = c;
	end
endmodule

// *** logic/dpc_top.sv ***
// digipot control: i2c target, register file, nvm sequencing
// assumes an external nvm array presenting images and taking writes
`timescale 1ns/1ps
module dpc_top
	import dpc_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC,
	parameter int OP_CYCLES  = NVM_OP_CYC
)(
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_o,
	input  wire logic             addr_strap_pin_i,
	input  wire logic [IMG_W-1:0] nvm_user_i,
	input  wire logic [9:0]       nvm_user_crc_i,
	input  wire logic [15:0]      nvm_fact_i,
	input  wire logic [9:0]       nvm_fact_crc_i,
	output logic                  nvm_wr_o,
	output logic [IMG_W-1:0]      nvm_wdata_o,
	output logic [9:0]            nvm_wcrc_o,
	output logic [7:0]            wiper_setting_o,
	output logic [1:0]            output_shutdown_select_o,
	output logic                  amp_off_o,
	output logic                  out_gnd_10k_o,
	output logic                  ref_en_o,
	output logic [1:0]            span_o,
	output logic                  bus_ready_o,
	output logic                  user_nvm_integrity_flag_o,
	output logic                  factory_nvm_integrity_flag_o,
	output logic                  persistent_mem_in_progress_o
);
	// refuse cycle counts that the 20-bit timer cannot hold
	if (POR_CYCLES < 1 || OP_CYCLES < 1 || POR_CYCLES >= 2**20 || OP_CYCLES >= 2**20)
	begin : g_bad_cycles
		$error("dpc_top: bad cycle parameters");
	end

	typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_RACK} dpc_i2c_t;
	typedef enum logic [1:0] {P_LOAD, P_WAIT, P_RUN, P_OP} dpc_ctl_t;

	dpc_i2c_t st_r;
	dpc_ctl_t ps_r;
	logic [2:0] pin_s, pin_p;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [3:0] cnt_r;
	logic [7:0] sh_r, ptr_r, hi_r, tx_r;
	logic [1:0] idx_r;
	logic rd_r, gc_r, txlo_r, mack_r, gc_fire_r, wr_go_r;
	logic strap_ne_scl_r, strap_ne_sda_r, strap_hi_r;
	logic [15:0] wr_data_r, rd_w;
	logic lock_r, ref_r, bypass_r, ufl_r, ffl_r, rel_r, soft_r;
	logic [1:0] pdn_r, span_r;
	logic [7:0] wiper_r, user1_r, user2_r;
	logic [19:0] tmr_r;
	logic [IMG_W-1:0] img_now;
	logic [9:0] crc_user, crc_fact, crc_now;
	logic user_bad, fact_bad, wr_ok;

	// read view of the register file
	function automatic logic [15:0] rd_word(input logic [7:0] p);
		logic [15:0] w;
		w = '0;
		if (p == CMD_STATUS)
		begin
			w[ST_USER_FLAG] = ufl_r;
			w[ST_FACT_FLAG] = ffl_r;
			w[ST_BUSY]      = (ps_r == P_OP);
			w[7:0]          = IDENT_CODE;
		end
		else if (p == CMD_CONFIG)
		begin
			w[CF_LOCK] = lock_r;
			w[CF_PDN_LO +: 2] = pdn_r;
			w[CF_REF_EN] = ref_r;
			w[CF_SPAN_LO +: 2] = span_r;
		end
		else if (p == CMD_WIPER)
			w[DATA_LO +: 8] = wiper_r;
		else if (p == CMD_USER1)
			w[DATA_LO +: 8] = user1_r;
		else if (p == CMD_USER2)
			w[DATA_LO +: 8] = user2_r;
		return w;
	endfunction

	// word the transmitter serves for the current pointer
	always_comb
	begin
		rd_w = rd_word(ptr_r);
	end

	// pins: scl, sda, strap through two flops
	dpc_sync #(.W(3)) u_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.d_i     ({scl_i, sda_i, addr_strap_pin_i}),
		.q_o     (pin_s)
	);

	// crc checks of both images and of the live image
	assign img_now = {lock_r, pdn_r, ref_r, span_r, wiper_r, user1_r, user2_r};
	dpc_crc10 #(.DW(IMG_W)) u_crc_user (.data_i(nvm_user_i), .crc_o(crc_user));
	dpc_crc10 #(.DW(16))    u_crc_fact (.data_i(nvm_fact_i), .crc_o(crc_fact));
	dpc_crc10 #(.DW(IMG_W)) u_crc_now  (.data_i(img_now),    .crc_o(crc_now));
	assign user_bad = (crc_user != nvm_user_crc_i);
	assign fact_bad = (crc_fact != nvm_fact_crc_i);

	// previous pin levels for edge finding
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pin_p <= '1;
		else
			pin_p <= pin_s;
	end
	assign scl_rise  = pin_s[2] & ~pin_p[2];
	assign scl_fall  = ~pin_s[2] & pin_p[2];
	assign start_det = pin_s[2] & pin_p[2] & pin_p[1] & ~pin_s[1];
	assign stop_det  = pin_s[2] & pin_p[2] & ~pin_p[1] & pin_s[1];

	// strap follows gnd, vdd, sda or scl during the address byte
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			strap_ne_scl_r <= 1'b0;
			strap_ne_sda_r <= 1'b0;
			strap_hi_r     <= 1'b0;
		end
		else if (start_det)
		begin
			strap_ne_scl_r <= 1'b0;
			strap_ne_sda_r <= 1'b0;
			strap_hi_r     <= pin_s[0];
		end
		else if (st_r == I_RX && idx_r == 2'd0)
		begin
			strap_ne_scl_r <= strap_ne_scl_r | (pin_s[0] != pin_s[2]);
			strap_ne_sda_r <= strap_ne_sda_r | (pin_s[0] != pin_s[1]);
			strap_hi_r     <= strap_hi_r | pin_s[0];
		end
	end

	// own address from fixed bits and strap
	function automatic logic [6:0] own_addr(input logic ne_scl, input logic ne_sda, input logic hi);
		logic [2:0] lo;
		lo = !ne_scl ? 3'd3 : !ne_sda ? 3'd2 : hi ? 3'd1 : 3'd0;
		return {DEV_ADDR_HI, lo};
	endfunction

	// i2c target engine, same at every scl rate
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r <= I_IDLE;
			cnt_r <= '0;
			sh_r <= '0;
			idx_r <= '0;
			ptr_r <= '0;
			hi_r <= '0;
			tx_r <= '0;
			rd_r <= 1'b0;
			gc_r <= 1'b0;
			txlo_r <= 1'b0;
			mack_r <= 1'b0;
			gc_fire_r <= 1'b0;
			wr_go_r <= 1'b0;
			wr_data_r <= '0;
			sda_oe_o <= 1'b0;
		end
		else
		begin
			gc_fire_r <= 1'b0;
			wr_go_r <= 1'b0;
			if (!bus_ready_o || stop_det)
			begin
				st_r <= I_IDLE;
				sda_oe_o <= 1'b0;
			end
			else if (start_det)
			begin
				st_r <= I_RX;
				cnt_r <= '0;
				idx_r <= '0;
				sda_oe_o <= 1'b0;
			end
			else
			begin
				case (st_r)
					I_RX:
					begin
						if (scl_rise)
						begin
							sh_r <= {sh_r[6:0], pin_s[1]};
							cnt_r <= cnt_r + 4'd1;
						end
						else if (scl_fall && cnt_r == 4'd8)
						begin
							st_r <= I_ACK;
							sda_oe_o <= 1'b1;
							if (idx_r == 2'd0)
							begin
								rd_r <= sh_r[0];
								gc_r <= (sh_r == GC_ADDR);
								if (!(sh_r[7:1] == own_addr(strap_ne_scl_r, strap_ne_sda_r, strap_hi_r)
									|| sh_r == GC_ADDR || sh_r == {BCAST_ADDR, 1'b0}))
								begin
									st_r <= I_IDLE;
									sda_oe_o <= 1'b0;
								end
							end
							else if (idx_r == 2'd1)
							begin
								ptr_r <= sh_r;
								if (gc_r && sh_r != GC_RESET)
								begin
									st_r <= I_IDLE;
									sda_oe_o <= 1'b0;
								end
							end
							else if (idx_r == 2'd2)
								hi_r <= sh_r;
							else
								wr_data_r <= {hi_r, sh_r};
						end
					end
					I_ACK:
					begin
						if (scl_rise && gc_r && idx_r == 2'd1)
							gc_fire_r <= 1'b1;
						else if (scl_fall)
						begin
							cnt_r <= '0;
							idx_r <= (idx_r == 2'd3) ? 2'd2 : idx_r + 2'd1;
							st_r <= I_RX;
							sda_oe_o <= 1'b0;
							if (idx_r == 2'd3)
								wr_go_r <= 1'b1;
							if (rd_r)
							begin
								tx_r <= rd_w[7:0];
								sh_r <= rd_w[15:8];
								txlo_r <= 1'b0;
								sda_oe_o <= ~rd_w[15];
								st_r <= I_TX;
							end
						end
					end
					I_TX:
					begin
						if (scl_fall)
						begin
							cnt_r <= cnt_r + 4'd1;
							if (cnt_r == 4'd7)
							begin
								st_r <= I_RACK;
								sda_oe_o <= 1'b0;
							end
							else
							begin
								sh_r <= {sh_r[6:0], 1'b0};
								sda_oe_o <= ~sh_r[6];
							end
						end
					end
					I_RACK:
					begin
						if (scl_rise)
							mack_r <= ~pin_s[1];
						else if (scl_fall)
						begin
							cnt_r <= '0;
							st_r <= I_IDLE;
							if (mack_r && !txlo_r)
							begin
								sh_r <= tx_r;
								txlo_r <= 1'b1;
								sda_oe_o <= ~tx_r[7];
								st_r <= I_TX;
							end
						end
					end
					default:
						st_r <= I_IDLE;
				endcase
			end
		end
	end

	// a write lands unless busy, or locked without the unlock key; protect stays reachable
	assign wr_ok = (ps_r == P_RUN) && (!lock_r || bypass_r || ptr_r == CMD_PROTECT);

	// register file and nvm sequencing
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ps_r <= P_LOAD;
			tmr_r <= '0;
			lock_r <= 1'b0;
			pdn_r <= PDN_HIZ;
			ref_r <= 1'b0;
			span_r <= SPAN_RST;
			wiper_r <= WIPER_RST;
			user1_r <= '0;
			user2_r <= '0;
			bypass_r <= 1'b0;
			ufl_r <= 1'b0;
			ffl_r <= 1'b0;
			rel_r <= 1'b0;
			soft_r <= 1'b0;
			nvm_wr_o <= 1'b0;
			nvm_wdata_o <= '0;
			nvm_wcrc_o <= '0;
		end
		else
		begin
			nvm_wr_o <= 1'b0;
			soft_r <= 1'b0;
			if (gc_fire_r || soft_r)
			begin
				ps_r <= P_LOAD;
				ufl_r <= 1'b0;
				ffl_r <= 1'b0;
				bypass_r <= 1'b0;
			end
			else if (ps_r == P_LOAD)
			begin
				ufl_r <= user_bad;
				ffl_r <= fact_bad;
				if (user_bad || fact_bad)
				begin
					{lock_r, pdn_r, ref_r, span_r} <= {1'b0, PDN_HIZ, 1'b0, SPAN_RST};
					{wiper_r, user1_r, user2_r} <= {WIPER_RST, 16'h0000};
				end
				else
					{lock_r, pdn_r, ref_r, span_r, wiper_r, user1_r, user2_r} <= nvm_user_i;
				tmr_r <= 20'(POR_CYCLES);
				ps_r <= rel_r ? P_RUN : P_WAIT;
				rel_r <= 1'b0;
			end
			else if (ps_r == P_WAIT || ps_r == P_OP)
			begin
				tmr_r <= tmr_r - 20'd1;
				if (tmr_r == 20'd1)
					ps_r <= (ps_r == P_OP && rel_r) ? P_LOAD : P_RUN;
			end
			else if (wr_go_r && wr_ok)
			begin
				if (ptr_r == CMD_CONFIG)
				begin
					lock_r <= wr_data_r[CF_LOCK];
					pdn_r <= wr_data_r[CF_PDN_LO +: 2];
					ref_r <= wr_data_r[CF_REF_EN];
					span_r <= wr_data_r[CF_SPAN_LO +: 2];
				end
				else if (ptr_r == CMD_WIPER)
					wiper_r <= wr_data_r[DATA_LO +: 8];
				else if (ptr_r == CMD_USER1)
					user1_r <= wr_data_r[DATA_LO +: 8];
				else if (ptr_r == CMD_USER2)
					user2_r <= wr_data_r[DATA_LO +: 8];
				else if (ptr_r == CMD_PROTECT)
				begin
					if (wr_data_r[PR_KEY_LO +: 4] == KEY_UNLOCK)
						bypass_r <= 1'b1;
					if (wr_data_r[PR_SOFT_LO +: 4] == KEY_SOFT)
						soft_r <= 1'b1;
					else if (wr_data_r[PR_RECALL])
					begin
						rel_r <= 1'b1;
						ps_r <= P_OP;
						tmr_r <= 20'(OP_CYCLES);
					end
					else if (wr_data_r[PR_STORE] && !ffl_r)
					begin
						nvm_wr_o <= 1'b1;
						nvm_wdata_o <= img_now;
						nvm_wcrc_o <= crc_now;
						ps_r <= P_OP;
						tmr_r <= 20'(OP_CYCLES);
					end
				end
			end
		end
	end

	// registered decode of the pin-facing controls
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			amp_off_o <= 1'b1;
			out_gnd_10k_o <= 1'b0;
			bus_ready_o <= 1'b0;
			persistent_mem_in_progress_o <= 1'b0;
			sda_o <= 1'b0;
		end
		else
		begin
			amp_off_o <= (pdn_r != PDN_ON);
			out_gnd_10k_o <= pdn_r[0];
			bus_ready_o <= (ps_r == P_RUN || ps_r == P_OP) && !gc_fire_r && !soft_r;
			persistent_mem_in_progress_o <= (ps_r == P_OP);
			sda_o <= 1'b0;
		end
	end
	assign wiper_setting_o = wiper_r;
	assign output_shutdown_select_o = pdn_r;
	assign ref_en_o = ref_r;
	assign span_o = span_r;
	assign user_nvm_integrity_flag_o = ufl_r;
	assign factory_nvm_integrity_flag_o = ffl_r;

	sequence s_load;
		ps_r == P_LOAD;
	endsequence
	sequence s_wait8;
		!bus_ready_o [*8];
	endsequence
	AST_POR_WAIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(s_load and ##0 !rel_r) |=> s_wait8) else $error("bus ready too soon");
	AST_CRC_FLAG: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(s_load and ##0 user_bad && !gc_fire_r && !soft_r) |=> ufl_r) else $error("user flag missed");
	AST_BUSY_NOWR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_go_r && ps_r == P_OP) |=> $stable(wiper_r) && $stable(pdn_r)) else $error("write while busy");
	AST_LOCKED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_go_r && lock_r && !bypass_r && ptr_r == CMD_WIPER) |=> $stable(wiper_r)) else $error("locked write");
	AST_STORE_BLK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ffl_r |=> !nvm_wr_o) else $error("store while factory alarm");
	AST_SOFT_KEY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_go_r && wr_ok && ptr_r == CMD_PROTECT && wr_data_r[PR_SOFT_LO +: 4] == KEY_SOFT)
		|=> ##1 (ps_r == P_LOAD && !ufl_r && !ffl_r)) else $error("soft restart missed");
	AST_GC_RESET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		gc_fire_r |=> s_load ##1 !bus_ready_o) else $error("general call reset missed");
	AST_ACK_HELD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(st_r == I_ACK && scl_rise && !rd_r) |-> sda_oe_o) else $error("ack not driven");
	AST_STOP_FREE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		stop_det |=> !sda_oe_o && st_r == I_IDLE) else $error("bus held after stop");
	AST_PULL_ONLY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		sda_oe_o |-> !sda_o) else $error("sda driven high");
endmodule

// *** test/dpc_i2c_ctl.sv ***
// i2c bus controller model that drives the target's scl and sda pins
// assumes the bench resolves sda as a wired-and line with a pull-up
`timescale 1ns/1ps
module dpc_i2c_ctl (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// idle bus: both lines released high
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// wait some falling edges of the core clock
	task automatic wt(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	// start or repeated start, sda falls while scl high
	task automatic start();
		sda_oe_o = 1'b0;
		wt(4);
		scl_o = 1'b1;
		wt(4);
		sda_oe_o = 1'b1;
		wt(4);
		scl_o = 1'b0;
		wt(1);
	endtask
	// stop, sda rises while scl high, then bus free
	task automatic stop();
		sda_oe_o = 1'b1;
		wt(3);
		scl_o = 1'b1;
		wt(4);
		sda_oe_o = 1'b0;
		wt(8);
	endtask
	// one bit: sda moves only while scl low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		sda_oe_o = !b;
		wt(3);
		scl_o = 1'b1;
		wt(2);
		r = sda_i;
		wt(2);
		scl_o = 1'b0;
		wt(1);
	endtask
	// send a byte, ack high when the target pulled sda low
	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// receive a byte, then answer with ack or nack
	task automatic rb(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(!ack, r);
	endtask
endmodule

// *** test/tb_digipot_i2c_target_control.sv ***
// self-checking bench for the digipot control block
// assumes the controller model in dpc_i2c_ctl and a pulled-up sda wire
`timescale 1ns/1ps
module tb_digipot_i2c_target_control;
	import dpc_pkg::*;
	localparam int POR_N = 50;
	localparam int OP_N  = 400;
	logic        clock_i, rst_n_i, scl, ctl_oe, sda_w, strap, ack;
	logic        sda_o, sda_oe, nvm_wr, amp_off, out_gnd, ref_en, ready, uflag, fflag, busy;
	logic [1:0]  strap_mode, pdn, span;
	logic [29:0] user_img, wdata, st_data;
	logic [9:0]  user_crc, fact_crc, wcrc, st_crc;
	logic [15:0] fact_img, rd;
	logic [7:0]  wiper;
	logic [6:0]  dev;
	int          fails, n_tests, n_store, n_busy, k;

	// clock and wired-and sda with pull-up
	always #50 clock_i = ~clock_i;
	assign sda_w = (ctl_oe || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
	assign strap = strap_mode[1] ? (strap_mode[0] ? scl : sda_w) : strap_mode[0];
	assign dev   = {DEV_ADDR_HI, 1'b0, strap_mode};

	dpc_i2c_ctl dpc_i2c_ctl_i (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(ctl_oe));

	dpc_top #(.POR_CYCLES(POR_N), .OP_CYCLES(OP_N)) dpc_top_i (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .addr_strap_pin_i(strap), .nvm_user_i(user_img), .nvm_user_crc_i(user_crc),
		.nvm_fact_i(fact_img), .nvm_fact_crc_i(fact_crc), .nvm_wr_o(nvm_wr), .nvm_wdata_o(wdata),
		.nvm_wcrc_o(wcrc), .wiper_setting_o(wiper), .output_shutdown_select_o(pdn), .amp_off_o(amp_off),
		.out_gnd_10k_o(out_gnd), .ref_en_o(ref_en), .span_o(span), .bus_ready_o(ready),
		.user_nvm_integrity_flag_o(uflag), .factory_nvm_integrity_flag_o(fflag),
		.persistent_mem_in_progress_o(busy)
	);

	// capture store pulses and count busy cycles, away from the launching edge
	always @(negedge clock_i)
	begin
		if (nvm_wr === 1'b1)
		begin
			n_store++;
			st_data = wdata;
			st_crc = wcrc;
		end
		if (busy === 1'b1)
			n_busy++;
	end

	// reference crc, zero seed, msb first
	function automatic logic [9:0] crc_of(input logic [29:0] d, input int n);
		logic [9:0] c;
		logic       fb;
		c = 10'h000;
		for (int i = n - 1; i >= 0; i--)
		begin
			fb = c[9] ^ d[i];
			c = {c[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
		end
		return c;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// bounded wait for the bus to open after a reset
	task automatic wait_ready(output int n);
		n = 0;
		while (ready !== 1'b1 && n < POR_N + 40)
		begin
			@(negedge clock_i);
			n++;
		end
		if (ready !== 1'b1)
		begin
			chk(ready, 1'b1);
			give_verdict();
		end
	endtask

	// register write: address, command, upper, lower
	task automatic reg_wr(input logic [7:0] cmd, input logic [15:0] d);
		dpc_i2c_ctl_i.start();
		dpc_i2c_ctl_i.wb({dev, 1'b0}, ack);
		chk(ack, 1'b1);
		dpc_i2c_ctl_i.wb(cmd, ack);
		chk(ack, 1'b1);
		dpc_i2c_ctl_i.wb(d[15:8], ack);
		chk(ack, 1'b1);
		dpc_i2c_ctl_i.wb(d[7:0], ack);
		chk(ack, 1'b1);
		dpc_i2c_ctl_i.stop();
	endtask

	// register read through a repeated start
	task automatic reg_rd(input logic [7:0] cmd, output logic [15:0] d);
		dpc_i2c_ctl_i.start();
		dpc_i2c_ctl_i.wb({dev, 1'b0}, ack);
		dpc_i2c_ctl_i.wb(cmd, ack);
		dpc_i2c_ctl_i.start();
		dpc_i2c_ctl_i.wb({dev, 1'b1}, ack);
		chk(ack, 1'b1);
		dpc_i2c_ctl_i.rb(1'b1, d[15:8]);
		dpc_i2c_ctl_i.rb(1'b0, d[7:0]);
		dpc_i2c_ctl_i.stop();
	endtask

	// soft restart through the protect key, then wait for the bus
	task automatic soft_restart();
		reg_wr(CMD_PROTECT, {10'h000, KEY_SOFT, 2'h0});
		chk(ready, 1'b0);
		wait_ready(k);
	endtask

	// main sequence
	initial
	begin
		clock_i = 1'b0;
		rst_n_i = 1'b0;
		strap_mode = 2'h0;
		user_img = {1'h0, 2'h1, 1'h0, 2'h3, 8'h3C, 8'hA5, 8'h5A};
		user_crc = crc_of(user_img, 30);
		fact_img = 16'h1234;
		fact_crc = crc_of({14'h0000, fact_img}, 16);
		repeat (10) @(negedge clock_i);
		rst_n_i = 1'b1;
		wait_ready(k);
		chk(k >= POR_N, 1'b1);
		chk({wiper, pdn, span, ref_en}, {8'h3C, 2'h1, 2'h3, 1'h0});
		chk({amp_off, out_gnd, uflag, fflag}, 4'hC);
		$display("test power-on load done");
		for (int s = 0; s < 4; s++)
		begin
			strap_mode = s[1:0];
			reg_wr(CMD_WIPER, {4'h0, 8'h10 + s[7:0], 4'h0});
			chk(wiper, 8'h10 + s[7:0]);
		end
		strap_mode = 2'h0;
		for (int j = 0; j < 2; j++)
		begin
			dpc_i2c_ctl_i.start();
			dpc_i2c_ctl_i.wb(j ? 8'hF0 : 8'h9E, ack);
			chk(ack, 1'b0);
			dpc_i2c_ctl_i.stop();
		end
		$display("test addressing done");
		for (int p = 0; p < 4; p++)
		begin
			reg_wr(CMD_CONFIG, {11'h000, p[1:0], !p[1], 2'h0});
			chk({pdn, amp_off, out_gnd, ref_en}, {p[1:0], p != 0, p[0], !p[1]});
		end
		reg_wr(CMD_WIPER, 16'h05A0);
		chk(wiper, 8'h5A);
		reg_rd(CMD_WIPER, rd);
		chk(rd[11:4], 8'h5A);
		$display("test shutdown and read done");
		reg_wr(CMD_CONFIG, 16'h2000);
		reg_wr(CMD_WIPER, 16'h0110);
		chk(wiper, 8'h5A);
		reg_wr(CMD_PROTECT, {KEY_UNLOCK, 12'h000});
		reg_wr(CMD_WIPER, 16'h0110);
		chk(wiper, 8'h11);
		$display("test lock done");
		n_busy = 0;
		reg_wr(CMD_PROTECT, 16'h0001);
		reg_wr(CMD_WIPER, 16'h0990);
		chk(wiper, 8'h11);
		repeat (OP_N + 20) @(negedge clock_i);
		chk(n_store, 1);
		chk(st_data, {1'h1, 2'h0, 1'h0, 2'h0, 8'h11, 8'hA5, 8'h5A});
		chk(st_crc, crc_of(st_data, 30));
		chk(n_busy >= OP_N, 1'b1);
		n_busy = 0;
		reg_wr(CMD_PROTECT, 16'h0002);
		repeat (OP_N + 20) @(negedge clock_i);
		chk({wiper, n_busy >= OP_N}, {8'h3C, 1'b1});
		reg_wr(CMD_WIPER, 16'h0770);
		soft_restart();
		chk({wiper, pdn}, {8'h3C, 2'h1});
		$display("test store and restart done");
		user_crc = user_crc ^ 10'h001;
		dpc_i2c_ctl_i.start();
		dpc_i2c_ctl_i.wb(GC_ADDR, ack);
		chk(ack, 1'b1);
		dpc_i2c_ctl_i.wb(GC_RESET, ack);
		chk(ready, 1'b0);
		dpc_i2c_ctl_i.stop();
		wait_ready(k);
		chk({uflag, fflag, wiper, pdn}, {2'h2, WIPER_RST, PDN_HIZ});
		reg_rd(CMD_STATUS, rd);
		chk(rd[15:14], 2'h2);
		reg_wr(CMD_WIPER, 16'h0440);
		chk(wiper, 8'h44);
		user_crc = crc_of(user_img, 30);
		soft_restart();
		chk({uflag, wiper}, {1'h0, 8'h3C});
		$display("test user alarm done");
		fact_crc = fact_crc ^ 10'h001;
		rst_n_i = 1'b0;
		repeat (10) @(negedge clock_i);
		rst_n_i = 1'b1;
		wait_ready(k);
		chk({fflag, wiper}, {1'h1, WIPER_RST});
		n_store = 0;
		reg_wr(CMD_PROTECT, 16'h0001);
		repeat (OP_N + 20) @(negedge clock_i);
		chk(n_store, 0);
		soft_restart();
		chk(fflag, 1'b1);
		fact_crc = crc_of({14'h0000, fact_img}, 16);
		soft_restart();
		chk(fflag, 1'b0);
		$display("test internal alarm done");
		give_verdict();
	end
endmodule
